// ===== pidsr_ctrl.sv
// Purpose: pid speed reference controller with axi4-lite register slave
// Assumes: analog samples and digital input synchronous to aclk
// Notes: loop recomputes once per sample tick
`timescale 1ns/1ps
module pidsr_ctrl #(
	parameter int TICK_CYCLES = pidsr_pkg::TICK_CYCLES_DEF
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [11:0] ain1_raw,
	input  wire logic [11:0] ain2_raw,
	input  wire logic        setpoint_switch_in,
	output logic [15:0]      speed_ref,
	output logic             pid_active
);
	localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
	// signed bound, keeps integrator compares signed
	localparam logic signed [39:0] PCT_FULL_S = $signed(40'(pidsr_pkg::PCT_FULL));

	pidsr_pkg::pidsr_state_t s;
	pidsr_pkg::pidsr_state_t next_s;

	// analog sample to percent by its format
	function automatic logic [14:0] to_pct(input logic [11:0] raw, input logic [1:0] fmt);
		logic [14:0] base;
		logic [17:0] lz;
		base = {1'b0, raw, 2'b00};
		lz = 18'((base - pidsr_pkg::PCT_LIVE_ZERO) * 5);
		unique case (fmt)
			pidsr_pkg::FMT_INV:      to_pct = pidsr_pkg::PCT_FULL - base;
			pidsr_pkg::FMT_LIVEZERO: to_pct = (base < pidsr_pkg::PCT_LIVE_ZERO) ? 15'h0 : lz[16:2];
			default:                 to_pct = base;
		endcase
	endfunction : to_pct

	// saturate a wide signed value into 0..full scale
	function automatic logic [14:0] clamp_pct(input logic signed [39:0] v);
		if (v < 0) begin
			clamp_pct = 15'h0;
		end else if (v > 40'(pidsr_pkg::PCT_FULL)) begin
			clamp_pct = pidsr_pkg::PCT_FULL;
		end else begin
			clamp_pct = v[14:0];
		end
	endfunction : clamp_pct

	// byte-lane merge of a write
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
			input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			old[i*8 +: 8] = strb[i] ? d[i*8 +: 8] : old[i*8 +: 8];
		end
		merge = old;
	endfunction : merge

	// address decode, shared by read and write
	function automatic logic addr_ok(input logic [7:0] a, input logic wr);
		unique case (a)
			pidsr_pkg::OFS_CTRL, pidsr_pkg::OFS_SP_PRI, pidsr_pkg::OFS_SP_SEC,
			pidsr_pkg::OFS_LIMITS, pidsr_pkg::OFS_SPEED, pidsr_pkg::OFS_GAIN_PI,
			pidsr_pkg::OFS_GAIN_D: addr_ok = 1'b1;
			pidsr_pkg::OFS_MONITOR, pidsr_pkg::OFS_SPEEDREF,
			pidsr_pkg::OFS_ERROR: addr_ok = !wr;
			default: addr_ok = 1'b0;
		endcase
	endfunction : addr_ok

	// read mux
	function automatic logic [31:0] read_reg(input pidsr_pkg::pidsr_state_t st, input logic [7:0] a);
		unique case (a)
			pidsr_pkg::OFS_CTRL:     read_reg = {16'h0, st.cfg.digital_input_function_select,
				st.cfg.analog_in2_format, st.cfg.analog_in1_format, st.cfg.output_limit_method,
				st.cfg.action_direction_mode, st.cfg.feedback_source_select,
				st.cfg.setpoint_source_select, st.cfg.speed_control_source};
			pidsr_pkg::OFS_SP_PRI:   read_reg = {17'h0, st.cfg.digital_setpoint_primary};
			pidsr_pkg::OFS_SP_SEC:   read_reg = {17'h0, st.cfg.digital_setpoint_secondary};
			pidsr_pkg::OFS_LIMITS:   read_reg = {1'b0, st.cfg.output_lower_limit_pct,
				1'b0, st.cfg.output_upper_limit_pct};
			pidsr_pkg::OFS_SPEED:    read_reg = {st.cfg.min_speed_limit, st.cfg.max_speed_limit};
			pidsr_pkg::OFS_GAIN_PI:  read_reg = {st.cfg.gain_i, st.cfg.gain_p};
			pidsr_pkg::OFS_GAIN_D:   read_reg = {16'h0, st.cfg.gain_d};
			pidsr_pkg::OFS_MONITOR:  read_reg = {17'h0, st.sp_pct};
			pidsr_pkg::OFS_SPEEDREF: read_reg = {16'h0, st.speed_ref};
			pidsr_pkg::OFS_ERROR:    read_reg = {{15{st.err[16]}}, st.err};
			default:                 read_reg = 32'h0;
		endcase
	endfunction : read_reg

	logic [14:0]        ain1_pct;
	logic [14:0]        ain2_pct;
	logic [14:0]        sp_sel_pct;
	logic [14:0]        fb_sel_pct;
	logic signed [16:0] err_now;
	logic signed [39:0] p_term;
	logic signed [39:0] i_step;
	logic signed [39:0] i_sum;
	logic signed [39:0] d_term;
	logic [14:0]        pid_pct;
	logic [14:0]        lim_pct;
	logic [31:0]        scaled;
	logic [31:0]        wval;

	// next state: bus slave, sample tick and control loop
	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		// write channels taken independently, answered when both are in
		if (s_axi_awvalid && s_axi_awready) begin
			next_s.aw_got = 1'b1;
			next_s.waddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_s.w_got = 1'b1;
			next_s.wdata = s_axi_wdata;
			next_s.wstrb = s_axi_wstrb;
		end
		wval = merge(read_reg(s, s.waddr), s.wdata, s.wstrb);
		if (s.aw_got && s.w_got) begin
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = addr_ok(s.waddr, 1'b1) ? pidsr_pkg::RESP_OKAY : pidsr_pkg::RESP_SLVERR;
			unique case (s.waddr)
				pidsr_pkg::OFS_CTRL: begin
					next_s.cfg.speed_control_source = wval[1:0];
					next_s.cfg.setpoint_source_select = wval[3:2];
					next_s.cfg.feedback_source_select = wval[4];
					next_s.cfg.action_direction_mode = wval[5];
					next_s.cfg.output_limit_method = wval[7:6];
					next_s.cfg.analog_in1_format = wval[9:8];
					next_s.cfg.analog_in2_format = wval[11:10];
					next_s.cfg.digital_input_function_select = wval[15:12];
				end
				pidsr_pkg::OFS_SP_PRI:  next_s.cfg.digital_setpoint_primary = wval[14:0];
				pidsr_pkg::OFS_SP_SEC:  next_s.cfg.digital_setpoint_secondary = wval[14:0];
				pidsr_pkg::OFS_LIMITS: begin
					next_s.cfg.output_upper_limit_pct = wval[14:0];
					next_s.cfg.output_lower_limit_pct = wval[30:16];
				end
				pidsr_pkg::OFS_SPEED: begin
					next_s.cfg.max_speed_limit = wval[15:0];
					next_s.cfg.min_speed_limit = wval[31:16];
				end
				pidsr_pkg::OFS_GAIN_PI: begin
					next_s.cfg.gain_p = wval[15:0];
					next_s.cfg.gain_i = wval[31:16];
				end
				pidsr_pkg::OFS_GAIN_D:  next_s.cfg.gain_d = wval[15:0];
				default: begin
				end
			endcase
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end
		// read answered the cycle after the address is taken
		if (s_axi_arvalid && s_axi_arready) begin
			next_s.rvalid = 1'b1;
			next_s.rdata = read_reg(s, s_axi_araddr);
			next_s.rresp = addr_ok(s_axi_araddr, 1'b0) ? pidsr_pkg::RESP_OKAY
				: pidsr_pkg::RESP_SLVERR;
		end else if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end

		// sample tick divider
		if (s.tick_cnt >= TICK_LAST) begin
			next_s.tick_cnt = 16'h0;
			next_s.tick = 1'b1;
		end else begin
			next_s.tick_cnt = s.tick_cnt + 16'h1;
		end

		// inputs as percent of full scale
		ain1_pct = to_pct(ain1_raw, s.cfg.analog_in1_format);
		ain2_pct = to_pct(ain2_raw, s.cfg.analog_in2_format);
		// set-point choice
		unique case (s.cfg.setpoint_source_select)
			pidsr_pkg::SPSEL_AIN1: sp_sel_pct = ain1_pct;
			pidsr_pkg::SPSEL_AIN2: sp_sel_pct = ain2_pct;
			default: begin
				// switch input only counts when configured for it
				sp_sel_pct = (s.cfg.digital_input_function_select == pidsr_pkg::DIFS_SP_SWITCH
					&& setpoint_switch_in) ? s.cfg.digital_setpoint_secondary
					: s.cfg.digital_setpoint_primary;
			end
		endcase
		// relies on software keeping set-point and feedback on different inputs
		fb_sel_pct = (s.cfg.feedback_source_select == pidsr_pkg::FBSEL_AIN2)
			? ain2_pct : ain1_pct;
		// error sign carries direct or inverse action
		err_now = (s.cfg.action_direction_mode == pidsr_pkg::DIR_DIRECT)
			? $signed({2'b00, sp_sel_pct}) - $signed({2'b00, fb_sel_pct})
			: $signed({2'b00, fb_sel_pct}) - $signed({2'b00, sp_sel_pct});
		// three terms, gains in 8.8 fixed point
		p_term = ($signed({24'h0, s.cfg.gain_p}) * 40'(err_now)) >>> 8;
		i_step = ($signed({24'h0, s.cfg.gain_i}) * 40'(err_now)) >>> 8;
		d_term = ($signed({24'h0, s.cfg.gain_d}) * (40'(err_now) - 40'(s.err_prev))) >>> 8;
		i_sum = 40'(s.integ) + i_step;
		// anti-windup: integrator kept within plus and minus full scale
		if (i_sum > PCT_FULL_S) begin
			i_sum = PCT_FULL_S;
		end else if (i_sum < -PCT_FULL_S) begin
			i_sum = -PCT_FULL_S;
		end
		pid_pct = clamp_pct(p_term + i_sum + d_term);
		// controller output limits, apart from drive speed limits
		unique case (s.cfg.output_limit_method)
			pidsr_pkg::LIM_AIN1_MAX: lim_pct = (pid_pct > ain1_pct) ? ain1_pct : pid_pct;
			pidsr_pkg::LIM_AIN1_MIN: lim_pct = (pid_pct < ain1_pct) ? ain1_pct : pid_pct;
			pidsr_pkg::LIM_AIN1_OFS: lim_pct = clamp_pct(40'(pid_pct) + 40'(ain1_pct));
			default: begin
				lim_pct = (pid_pct < s.cfg.output_lower_limit_pct)
					? s.cfg.output_lower_limit_pct : pid_pct;
				lim_pct = (lim_pct > s.cfg.output_upper_limit_pct)
					? s.cfg.output_upper_limit_pct : lim_pct;
			end
		endcase
		// percent of maximum speed into speed units
		scaled = (32'(s.out_pct) * 32'(s.cfg.max_speed_limit)) >> 14;

		if (s.cfg.speed_control_source != pidsr_pkg::SRC_PID) begin
			next_s.integ = 32'sh0;
			next_s.err_prev = 17'sh0;
			next_s.out_pct = 15'h0;
			next_s.speed_ref = 16'h0;
		end else begin
			if (s.tick) begin
				next_s.sp_pct = sp_sel_pct;
				next_s.fb_pct = fb_sel_pct;
				next_s.err = err_now;
				next_s.err_prev = err_now;
				next_s.integ = 32'(i_sum);
				next_s.out_pct = lim_pct;
			end
			// general drive floor applied after the controller limits
			next_s.speed_ref = (scaled[15:0] < s.cfg.min_speed_limit)
				? s.cfg.min_speed_limit : scaled[15:0];
		end
	end

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.cfg.output_upper_limit_pct <= pidsr_pkg::PCT_FULL;
			s.cfg.max_speed_limit <= pidsr_pkg::RST_VMAX;
			s.cfg.gain_p <= pidsr_pkg::RST_KP;
		end else begin
			s <= next_s;
		end
	end

	// outputs
	assign s_axi_awready = !s.aw_got && !s.bvalid;
	assign s_axi_wready  = !s.w_got && !s.bvalid;
	assign s_axi_bvalid  = s.bvalid;
	assign s_axi_bresp   = s.bresp;
	assign s_axi_arready = !s.rvalid;
	assign s_axi_rvalid  = s.rvalid;
	assign s_axi_rdata   = s.rdata;
	assign s_axi_rresp   = s.rresp;
	assign speed_ref     = s.speed_ref;
	assign pid_active    = (s.cfg.speed_control_source == pidsr_pkg::SRC_PID);

	// checks
	a_inactive_zero_ref: assert property (@(posedge aclk) disable iff (!aresetn)
		(s.cfg.speed_control_source != pidsr_pkg::SRC_PID)[*2] |-> speed_ref == 16'h0)
		else $error("speed reference not zero while pid disabled");
	a_monitor_primary: assert property (@(posedge aclk) disable iff (!aresetn)
		s.tick && pid_active && s.cfg.setpoint_source_select == pidsr_pkg::SPSEL_DIG
		&& s.cfg.digital_input_function_select != pidsr_pkg::DIFS_SP_SWITCH
		|=> s.sp_pct == $past(s.cfg.digital_setpoint_primary))
		else $error("monitor does not show primary digital set-point");
	a_secondary_pick: assert property (@(posedge aclk) disable iff (!aresetn)
		s.tick && pid_active && s.cfg.setpoint_source_select == pidsr_pkg::SPSEL_DIG
		&& s.cfg.digital_input_function_select == pidsr_pkg::DIFS_SP_SWITCH
		&& setpoint_switch_in |=> s.sp_pct == $past(s.cfg.digital_setpoint_secondary))
		else $error("monitor does not show secondary digital set-point");
	a_feedback_ain2: assert property (@(posedge aclk) disable iff (!aresetn)
		s.tick && pid_active && s.cfg.feedback_source_select == pidsr_pkg::FBSEL_AIN2
		|=> s.fb_pct == $past(ain2_pct))
		else $error("feedback does not follow analog input 2");
	a_disabled_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		!pid_active |=> s.out_pct == 15'h0 && s.integ == 32'sh0)
		else $error("controller state not cleared while pid disabled");
	a_out_full_scale: assert property (@(posedge aclk) disable iff (!aresetn)
		s.out_pct <= pidsr_pkg::PCT_FULL)
		else $error("controller output above full scale");
	a_speed_floor: assert property (@(posedge aclk) disable iff (!aresetn)
		$past(aresetn) && $past(pid_active) |-> speed_ref >= $past(s.cfg.min_speed_limit))
		else $error("speed reference below general minimum");
	a_monitor_ain1: assert property (@(posedge aclk) disable iff (!aresetn)
		s.tick && pid_active && s.cfg.setpoint_source_select == pidsr_pkg::SPSEL_AIN1
		&& s.cfg.analog_in1_format == pidsr_pkg::FMT_UNI
		|=> s.sp_pct == {1'b0, $past(ain1_raw), 2'b00})
		else $error("monitor does not follow analog input 1");
	a_direct_error: assert property (@(posedge aclk) disable iff (!aresetn)
		s.tick && pid_active && s.cfg.action_direction_mode == pidsr_pkg::DIR_DIRECT
		&& s.cfg.setpoint_source_select == pidsr_pkg::SPSEL_AIN1
		&& s.cfg.feedback_source_select == pidsr_pkg::FBSEL_AIN2
		&& s.cfg.analog_in1_format == pidsr_pkg::FMT_UNI
		&& s.cfg.analog_in2_format == pidsr_pkg::FMT_UNI
		|=> s.err == $signed({3'b000, $past(ain1_raw), 2'b00}) - $signed({3'b000, $past(ain2_raw), 2'b00}))
		else $error("direct error is not set-point minus feedback");
	a_inverse_sign: assert property (@(posedge aclk) disable iff (!aresetn)
		s.tick && pid_active && s.cfg.action_direction_mode != pidsr_pkg::DIR_DIRECT
		|=> s.err == $signed({2'b00, s.fb_pct}) - $signed({2'b00, s.sp_pct}))
		else $error("inverse error has wrong sign");
	a_upper_limit: assert property (@(posedge aclk) disable iff (!aresetn)
		s.tick && pid_active && s.cfg.output_limit_method == pidsr_pkg::LIM_DIGITAL
		|=> s.out_pct <= $past(s.cfg.output_upper_limit_pct))
		else $error("output above digital upper limit");
	a_lower_limit: assert property (@(posedge aclk) disable iff (!aresetn)
		s.tick && pid_active && s.cfg.output_limit_method == pidsr_pkg::LIM_DIGITAL
		&& s.cfg.output_lower_limit_pct <= s.cfg.output_upper_limit_pct
		|=> s.out_pct >= $past(s.cfg.output_lower_limit_pct))
		else $error("output below digital lower limit");
	a_ain1_max: assert property (@(posedge aclk) disable iff (!aresetn)
		s.tick && pid_active && s.cfg.output_limit_method == pidsr_pkg::LIM_AIN1_MAX
		|=> s.out_pct <= $past(ain1_pct))
		else $error("output above analog maximum");
	a_ain1_min: assert property (@(posedge aclk) disable iff (!aresetn)
		s.tick && pid_active && s.cfg.output_limit_method == pidsr_pkg::LIM_AIN1_MIN
		|=> s.out_pct >= $past(ain1_pct))
		else $error("output below analog minimum");
	a_ain1_offset: assert property (@(posedge aclk) disable iff (!aresetn)
		s.tick && pid_active && s.cfg.output_limit_method == pidsr_pkg::LIM_AIN1_OFS
		|=> s.out_pct >= $past(ain1_pct))
		else $error("analog offset not added");
	a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before bready");
endmodule : pidsr_ctrl

// ===== pidsr_far_model.sv
// Purpose: far side model, analog samplers and set-point switch contact
// Assumes: samplers deliver a fresh 12-bit code each aclk
// Notes: one cycle of sampler delay between the bench request and the pins
`timescale 1ns/1ps
module pidsr_far_model (
	input  wire logic        aclk,
	input  wire logic [11:0] ain1_set,
	input  wire logic [11:0] ain2_set,
	input  wire logic        sw_set,
	output logic [11:0]      ain1_raw,
	output logic [11:0]      ain2_raw,
	output logic             setpoint_switch_in
);
	// sampled analog codes and contact state, registered like a real converter
	always_ff @(posedge aclk) begin
		ain1_raw           <= ain1_set;
		ain2_raw           <= ain2_set;
		setpoint_switch_in <= sw_set;
	end
endmodule : pidsr_far_model

// ===== pidsr_pkg.sv
// Purpose: shared constants and types of the pid speed reference controller
// Assumes: percentages are unsigned, 16384 counts equal 100 %
// Notes: analog samples are 12-bit, left shifted by two into percent counts
package pidsr_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_SP_PRI   = 8'h04;
	localparam logic [7:0] OFS_SP_SEC   = 8'h08;
	localparam logic [7:0] OFS_LIMITS   = 8'h0c;
	localparam logic [7:0] OFS_SPEED    = 8'h10;
	localparam logic [7:0] OFS_GAIN_PI  = 8'h14;
	localparam logic [7:0] OFS_GAIN_D   = 8'h18;
	localparam logic [7:0] OFS_MONITOR  = 8'h1c;
	localparam logic [7:0] OFS_SPEEDREF = 8'h20;
	localparam logic [7:0] OFS_ERROR    = 8'h24;

	// control field values
	localparam logic [1:0] SRC_PID      = 2'h3;
	localparam logic [1:0] SPSEL_DIG    = 2'h0;
	localparam logic [1:0] SPSEL_AIN1   = 2'h1;
	localparam logic [1:0] SPSEL_AIN2   = 2'h2;
	localparam logic       FBSEL_AIN2   = 1'h0;
	localparam logic       DIR_DIRECT   = 1'h0;
	localparam logic [1:0] LIM_DIGITAL  = 2'h0;
	localparam logic [1:0] LIM_AIN1_MAX = 2'h1;
	localparam logic [1:0] LIM_AIN1_MIN = 2'h2;
	localparam logic [1:0] LIM_AIN1_OFS = 2'h3;
	localparam logic [1:0] FMT_UNI      = 2'h0;
	localparam logic [1:0] FMT_INV      = 2'h1;
	localparam logic [1:0] FMT_LIVEZERO = 2'h2;
	localparam logic [3:0] DIFS_SP_SWITCH = 4'h8;

	// percent scale
	localparam logic [14:0] PCT_FULL      = 15'h4000;
	localparam logic [14:0] PCT_LIVE_ZERO = 15'h0ccd;

	// reset values
	localparam logic [15:0] RST_VMAX = 16'h05dc;
	localparam logic [15:0] RST_KP   = 16'h0100;

	// sample tick timing
	localparam int SAMPLE_PERIOD_US = 1000;
	localparam int CLK_MHZ          = 40;
	localparam int TICK_CYCLES_DEF  = SAMPLE_PERIOD_US * CLK_MHZ;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [1:0]  speed_control_source;
		logic [1:0]  setpoint_source_select;
		logic        feedback_source_select;
		logic        action_direction_mode;
		logic [1:0]  output_limit_method;
		logic [1:0]  analog_in1_format;
		logic [1:0]  analog_in2_format;
		logic [3:0]  digital_input_function_select;
		logic [14:0] digital_setpoint_primary;
		logic [14:0] digital_setpoint_secondary;
		logic [14:0] output_upper_limit_pct;
		logic [14:0] output_lower_limit_pct;
		logic [15:0] max_speed_limit;
		logic [15:0] min_speed_limit;
		logic [15:0] gain_p;
		logic [15:0] gain_i;
		logic [15:0] gain_d;
	} pidsr_cfg_t;

	typedef struct packed {
		pidsr_cfg_t         cfg;
		logic               aw_got;
		logic               w_got;
		logic [7:0]         waddr;
		logic [31:0]        wdata;
		logic [3:0]         wstrb;
		logic               bvalid;
		logic [1:0]         bresp;
		logic               rvalid;
		logic [31:0]        rdata;
		logic [1:0]         rresp;
		logic [15:0]        tick_cnt;
		logic               tick;
		logic [14:0]        sp_pct;
		logic [14:0]        fb_pct;
		logic signed [16:0] err;
		logic signed [16:0] err_prev;
		logic signed [31:0] integ;
		logic [14:0]        out_pct;
		logic [15:0]        speed_ref;
	} pidsr_state_t;
endpackage : pidsr_pkg

// ===== tb.sv
// Purpose: self-checking bench of the pid speed reference controller
// Assumes: unity proportional gain, zero integral and derivative gains
// Notes: short sample tick keeps the run brief
`timescale 1ns/1ps
module tb;
	localparam int TICK   = 8;
	localparam int SETTLE = 3 * TICK + 6;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rd;
	logic [3:0]  wstrb = 4'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, pid_active, sw, sw_set = 1'b0;
	logic [1:0]  bresp, rresp, rs;
	logic [31:0] rdata, r, st = 32'd16808;
	logic [15:0] speed_ref;
	logic [11:0] a1r = 12'h0, a2r = 12'h0, ain1_raw, ain2_raw;
	int          miscompares = 0, checks = 0, cycles = 0;
	int          sp, fb, up, lo, mx, mn, e;
	logic [15:0] dctl [7] = '{16'h0003, 16'h8003, 16'h8003, 16'h0007, 16'h001b, 16'h0107,
		16'h081b};
	logic        dsw [7]  = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
	int          dexp [7] = '{1000, 2000, 1000, 1024, 4096, 15360, 1023};

	pidsr_ctrl #(.TICK_CYCLES(TICK)) i_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.ain1_raw(ain1_raw), .ain2_raw(ain2_raw), .setpoint_switch_in(sw),
		.speed_ref(speed_ref), .pid_active(pid_active));
	pidsr_far_model i_far (.aclk(aclk), .ain1_set(a1r), .ain2_set(a2r), .sw_set(sw_set),
		.ain1_raw(ain1_raw), .ain2_raw(ain2_raw), .setpoint_switch_in(sw));

	// clock and hang guard
	always #12.5 aclk = ~aclk;
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			conclude();
		end
	end

	function automatic logic [31:0] xs();
		st = st ^ (st << 13);
		st = st ^ (st >> 17);
		st = st ^ (st << 5);
		return st;
	endfunction : xs

	// expected speed reference at unity gain
	function automatic int exp_speed(int sp, int fb, logic dir, logic [1:0] meth, int up,
		int lo, int a1, int mx, int mn);
		int v;
		v = dir ? fb - sp : sp - fb;
		v = (v < 0) ? 0 : ((v > 16384) ? 16384 : v);
		case (meth)
			2'h0: begin
				v = (v < lo) ? lo : v;
				v = (v > up) ? up : v;
			end
			2'h1: v = (v > a1) ? a1 : v;
			2'h2: v = (v < a1) ? a1 : v;
			default: v = (v + a1 > 16384) ? 16384 : v + a1;
		endcase
		v = (v * mx) >>> 14;
		return (v < mn) ? mn : v;
	endfunction : exp_speed

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!(bvalid && bready));
		bready <= 1'b0;
		resp = bresp;
	endtask : axw

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!(rvalid && rready));
		rready <= 1'b0;
		d = rdata;
		resp = rresp;
	endtask : axr

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		axw(a, d, rs);
		check(32'(rs), 32'(pidsr_pkg::RESP_OKAY), "write response");
	endtask : wr

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		axr(a, rd, rs);
		check(rd, exp, what);
	endtask : rdchk

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : conclude

	// main sequence
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		check(32'(speed_ref), 32'h0, "idle speed");
		check(32'(pid_active), 32'h0, "idle active");
		rdchk(pidsr_pkg::OFS_CTRL, 32'h0, "ctrl reset");
		rdchk(pidsr_pkg::OFS_LIMITS, 32'h00004000, "limits reset");
		rdchk(pidsr_pkg::OFS_SPEED, 32'h000005dc, "speed reset");
		axr(8'h28, rd, rs);
		check({rd[29:0], rs}, {30'h0, pidsr_pkg::RESP_SLVERR}, "unmapped read");
		axw(pidsr_pkg::OFS_SPEEDREF, 32'h1234, rs);
		check(32'(rs), 32'(pidsr_pkg::RESP_SLVERR), "read-only write");
		$display("test reset_and_bus done");
		// set-point source table, feedback never on the set-point input
		wr(pidsr_pkg::OFS_SP_PRI, 32'd1000);
		wr(pidsr_pkg::OFS_SP_SEC, 32'd2000);
		a1r <= 12'h100;
		a2r <= 12'h400;
		for (int i = 0; i < 7; i++) begin
			sw_set <= dsw[i];
			wr(pidsr_pkg::OFS_CTRL, {16'h0, dctl[i]});
			repeat (SETTLE) @(posedge aclk);
			rdchk(pidsr_pkg::OFS_MONITOR, 32'(dexp[i]), "set-point monitor");
		end
		$display("test setpoint_select done");
		// random loop, each limit method and a disabled case forced first
		for (int n = 0; n < 40; n++) begin
			r = xs();
			if (n < 4) r[2:1] = 2'(n);
			if (n == 4) r[7:4] = 4'h0;
			sp = int'(xs() % 16385);
			up = int'(xs() % 16385);
			lo = int'(xs() % 16385);
			mx = int'(xs() & 32'hffff);
			mn = int'(xs() & 32'h00ff);
			a1r <= r[19:8];
			a2r <= 12'(xs());
			sw_set <= r[20];
			wr(pidsr_pkg::OFS_SP_PRI, 32'(sp));
			wr(pidsr_pkg::OFS_LIMITS, {1'b0, 15'(lo), 1'b0, 15'(up)});
			wr(pidsr_pkg::OFS_SPEED, {16'(mn), 16'(mx)});
			wr(pidsr_pkg::OFS_CTRL, {24'h0, r[2:1], r[0], r[3], 2'h0, (r[7:4] == 4'h0) ? 2'h1 : 2'h3});
			repeat (SETTLE) @(posedge aclk);
			fb = r[3] ? int'(a1r) * 4 : int'(a2r) * 4;
			e = r[0] ? fb - sp : sp - fb;
			if (r[7:4] == 4'h0) begin
				check(32'(speed_ref), 32'h0, "disabled speed");
			end else begin
				check(32'(pid_active), 32'h1, "active flag");
				check(32'(speed_ref), 32'(exp_speed(sp, fb, r[0], r[2:1], up, lo, int'(a1r) * 4,
					mx, mn)), "speed reference");
				rdchk(pidsr_pkg::OFS_ERROR, 32'(e), "error value");
			end
		end
		$display("test random_loop done");
		conclude();
	end
endmodule : tb
